/* design/gate_driver_control.sv */
// Three-phase gate control: truth table, dead time, minimum on-time and
// lock-out handling. Inputs are pins or other-domain levels and are
// synchronised here; lock-out levels come from analog comparators.
`timescale 1ns/10ps
module gate_driver_control
  import gate_drive_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // Command sources: port bit and PWM phase outputs
  input  wire logic                driver_enable_port_bit,
  input  wire logic [PHASES-1:0]   pwm_top_phase,
  input  wire logic [PHASES-1:0]   pwm_bottom_phase,
  // Presence of a driver on the command lines (pull emulation)
  input  wire logic                enable_driven,
  input  wire logic [PHASES-1:0]   cmd_driven,
  // Lock-out levels, high while the condition holds
  input  wire logic                supply_lockout,
  input  wire logic                regulator_lockout,
  input  wire logic                thermal_lockout,
  input  wire logic [PHASES-1:0]   bootstrap_lockout,
  // Gate outputs
  output gate_out_type             gates
);

  // ----------------------------------------------------------------
  // Two-stage synchronisers on every pin and lock-out level
  // ----------------------------------------------------------------
  localparam int SW = 4 * PHASES + 5;
  // Reset value keeps every gate off and every lock-out asserted
  localparam logic [SW-1:0] SYNC_RST = {1'b0, {PHASES{1'b0}},
                                        {PHASES{1'b1}}, 1'b0,
                                        {PHASES{1'b0}}, 3'h7,
                                        {PHASES{1'b1}}};
  logic [SW-1:0] sync1, sync2, next_sync1, next_sync2;
  always_comb begin
    next_sync1 = {driver_enable_port_bit, pwm_top_phase, pwm_bottom_phase,
                  enable_driven, cmd_driven, supply_lockout,
                  regulator_lockout, thermal_lockout, bootstrap_lockout};
    next_sync2 = sync1;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
    end
  end

  // ----------------------------------------------------------------
  // Pull defaults and source mapping
  // ----------------------------------------------------------------
  logic              en_pin, en_drv, sup_s, reg_s, otp_s, en_s;
  logic [PHASES-1:0] top_pin, bot_pin, cmd_drv, bst_s;
  phase_cmd_type     cmd_s;
  assign {en_pin, top_pin, bot_pin, en_drv, cmd_drv,
          sup_s, reg_s, otp_s, bst_s} = sync2;
  // Pulls act after the flip-flops, so no logic reads a raw pin
  always_comb begin
    // Undriven lines fall to the off state of the bridge
    en_s                 = en_drv & en_pin;
    cmd_s.high_side_cmd  = cmd_drv & top_pin;
    cmd_s.low_side_cmd_n = ~cmd_drv | bot_pin;
  end

  // Truth-table decode shared by every phase
  function automatic drive_type decode(input logic en, input logic hi,
                                       input logic lo_n);
    if (!en)
      decode = DRV_OFF;
    else if (!hi && !lo_n)
      decode = DRV_LOW;
    else if (hi && lo_n)
      decode = DRV_HIGH;
    else
      decode = DRV_OFF;
  endfunction

  // ----------------------------------------------------------------
  // Per-phase filter, dead time and output stage
  // ----------------------------------------------------------------
  drive_type          want   [PHASES];
  drive_type          cand   [PHASES];
  drive_type          active [PHASES];
  logic [CNT_W-1:0]   on_cnt [PHASES];
  logic [CNT_W-1:0]   dead   [PHASES];
  drive_type          next_cand   [PHASES];
  drive_type          next_active [PHASES];
  logic [CNT_W-1:0]   next_on_cnt [PHASES];
  logic [CNT_W-1:0]   next_dead   [PHASES];
  logic [PHASES-1:0]  hi_q, lo_q, next_hi, next_lo;
  logic               hard_off;

  assign hard_off = sup_s | reg_s | otp_s;

  always_comb begin
    for (int p = 0; p < PHASES; p++) begin
      want[p]        = decode(en_s, cmd_s.high_side_cmd[p],
                              cmd_s.low_side_cmd_n[p]);
      next_cand[p]   = want[p];
      next_on_cnt[p] = on_cnt[p];
      next_active[p] = active[p];
      next_dead[p]   = dead[p];
      // Qualify a drive request only after it persists the minimum on-time
      if (want[p] != cand[p])
        next_on_cnt[p] = '0;
      else if (on_cnt[p] < CNT_W'(MINON_CYCLES))
        next_on_cnt[p] = on_cnt[p] + CNT_W'(1);
      // Dead counter runs while the phase's active drive is DRV_OFF
      if (active[p] == DRV_OFF) begin
        if (dead[p] < CNT_W'(DEAD_CYCLES))
          next_dead[p] = dead[p] + CNT_W'(1);
      end else begin
        next_dead[p] = '0;
      end
      // Off requests drop at once; on requests need filter and dead time
      if (want[p] == DRV_OFF || want[p] != active[p])
        next_active[p] = DRV_OFF;
      if (active[p] == DRV_OFF && want[p] != DRV_OFF &&
          want[p] == cand[p] &&
          on_cnt[p] >= CNT_W'(MINON_CYCLES - 1) &&
          dead[p] >= CNT_W'(DEAD_CYCLES - 1))
        next_active[p] = want[p];
      // Lock-out gating on the registered outputs
      next_hi[p] = (next_active[p] == DRV_HIGH) && !hard_off
                   && !bst_s[p];
      next_lo[p] = (next_active[p] == DRV_LOW) && !hard_off;
    end
  end

  // Registered state; the gates leave flip-flops to avoid glitches
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int p = 0; p < PHASES; p++) begin
        cand[p]   <= DRV_OFF;
        active[p] <= DRV_OFF;
        on_cnt[p] <= '0;
        dead[p]   <= CNT_W'(DEAD_CYCLES);
      end
      hi_q <= '0;
      lo_q <= '0;
    end else begin
      for (int p = 0; p < PHASES; p++) begin
        cand[p]   <= next_cand[p];
        active[p] <= next_active[p];
        on_cnt[p] <= next_on_cnt[p];
        dead[p]   <= next_dead[p];
      end
      hi_q <= next_hi;
      lo_q <= next_lo;
    end
  end

  // One driver for the whole output word
  assign gates = {hi_q, lo_q};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Helpers on phase 0: both-off run, last side driven, low request run
  logic [CNT_W-1:0] gap_cnt, next_gap_cnt, low_run, next_low_run;
  logic             last_hi, next_last_hi;
  always_comb begin
    next_gap_cnt = gap_cnt;
    next_low_run = low_run;
    next_last_hi = last_hi;
    if (hi_q[0] || lo_q[0])
      next_gap_cnt = '0;
    else if (gap_cnt < CNT_W'(DEAD_CYCLES))
      next_gap_cnt = gap_cnt + CNT_W'(1);
    if (want[0] != DRV_LOW)
      next_low_run = '0;
    else if (low_run < CNT_W'(MINON_CYCLES))
      next_low_run = low_run + CNT_W'(1);
    if (hi_q[0])
      next_last_hi = 1'b1;
    else if (lo_q[0])
      next_last_hi = 1'b0;
  end
  // Gap starts saturated, matching the dead counter after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      gap_cnt <= CNT_W'(DEAD_CYCLES);
      low_run <= '0;
      last_hi <= 1'b0;
    end else begin
      gap_cnt <= next_gap_cnt;
      low_run <= next_low_run;
      last_hi <= next_last_hi;
    end
  end

  property p_no_shoot;
    @(posedge clk) disable iff (rst) (hi_q & lo_q) == '0;
  endproperty
  a_no_shoot: assert property (p_no_shoot)
    else $error("both gates on");

  // Only a changeover needs the gap; a lock-out pause on one side does not
  property p_dead_gap;
    @(posedge clk) disable iff (rst)
      (($rose(lo_q[0]) && last_hi) || ($rose(hi_q[0]) && !last_hi))
        |-> gap_cnt >= CNT_W'(DEAD_CYCLES);
  endproperty
  a_dead_gap: assert property (p_dead_gap)
    else $error("dead gap short");

  property p_hard_off;
    @(posedge clk) disable iff (rst) hard_off |=> (hi_q == '0 && lo_q == '0);
  endproperty
  a_hard_off: assert property (p_hard_off)
    else $error("lockout ignored");

  property p_bst;
    @(posedge clk) disable iff (rst) bst_s[0] |=> !hi_q[0];
  endproperty
  a_bst: assert property (p_bst)
    else $error("high gate in bst lockout");

  property p_en_off;
    @(posedge clk) disable iff (rst) !en_s |=> (hi_q == '0 && lo_q == '0);
  endproperty
  a_en_off: assert property (p_en_off)
    else $error("gate on while disabled");

  property p_low_cause;
    @(posedge clk) disable iff (rst)
      $rose(lo_q[0]) |-> $past(!cmd_s.high_side_cmd[0] &&
                               !cmd_s.low_side_cmd_n[0] && en_s);
  endproperty
  a_low_cause: assert property (p_low_cause)
    else $error("low without cmd");

  property p_high_cause;
    @(posedge clk) disable iff (rst)
      $rose(hi_q[0]) |-> $past(want[0] == DRV_HIGH, 1)
                         && $past(want[0] == DRV_HIGH, 2);
  endproperty
  a_high_cause: assert property (p_high_cause)
    else $error("short pulse passed");

  // Low gate only after the low request has stood the minimum on-time
  property p_minon;
    @(posedge clk) disable iff (rst)
      $rose(lo_q[0]) |-> low_run >= CNT_W'(MINON_CYCLES);
  endproperty
  a_minon: assert property (p_minon)
    else $error("short low pulse passed");

endmodule // gate_driver_control

/* design/gate_drive_pkg.sv */
// Shared constants and carrier types for the three-phase gate control.
// Assumes a single 200 MHz clock and synchronous active-high reset.
package gate_drive_pkg;

  // ----------------------------------------------------------------
  // Geometry and timing
  // ----------------------------------------------------------------
  localparam int PHASES          = 3;
  localparam int CLK_PERIOD_PS   = 5000;
  // Built-in dead interval and minimum on-time, in ns as set
  localparam int DEAD_TIME_NS    = 200;
  localparam int MIN_ON_NS       = 100;
  // Least times round up to whole cycles, at least one
  localparam int DEAD_CYCLES_RAW = (DEAD_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;
  localparam int DEAD_CYCLES     = (DEAD_CYCLES_RAW < 1) ? 1 : DEAD_CYCLES_RAW;
  localparam int MINON_RAW       = (MIN_ON_NS * 1000 + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;
  localparam int MINON_CYCLES    = (MINON_RAW < 1) ? 1 : MINON_RAW;
  localparam int CNT_W           = 8;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [PHASES-1:0] high_side_cmd;
    logic [PHASES-1:0] low_side_cmd_n;
  } phase_cmd_type;

  typedef struct packed {
    logic [PHASES-1:0] high_gate_out;
    logic [PHASES-1:0] low_gate_out;
  } gate_out_type;

  typedef enum logic [1:0] {
    DRV_OFF,
    DRV_LOW,
    DRV_HIGH
  } drive_type;

endpackage

/* verif/pwm_source_model.sv */
// Far-side model: motor PWM top/bottom lines and the enable port bit.
// Assumes the bench hands it requested levels in step with clk.
`timescale 1ns/10ps
module pwm_source_model
  import gate_drive_pkg::*;
#(
  parameter int CHARGE = 50
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Requested levels
  input  wire logic              en_req,
  input  wire logic [PHASES-1:0] top_req,
  input  wire logic [PHASES-1:0] bot_req,
  // Lines to the gate control
  output logic                   en,
  output logic [PHASES-1:0]      top,
  output logic [PHASES-1:0]      bot
);
  int  left;
  logic hold;

  // Charge window; kept short so the run stays brief
  assign hold = (left > 0) || (en_req && !en);
  // Low sides on for a while after each enable, then pass requests
  always_ff @(posedge clk) begin
    en <= en_req;
    if (rst || (en_req && !en)) left <= CHARGE;
    else if (left > 0) left <= left - 1;
    top <= hold ? '0 : top_req;
    bot <= hold ? '0 : bot_req;
  end
endmodule // pwm_source_model

/* verif/gate_driver_control_test.sv */
// Self-checking bench for the three-phase gate control.
// Assumes the package timing constants and the PWM source model.
`timescale 1ns/10ps
module gate_driver_control_test;
  import gate_drive_pkg::*;
  localparam int HOLD = 160;
  logic              clk = 0, rst = 1, en_req = 0, enable_driven = 1;
  logic [PHASES-1:0] top_req = '0, bot_req = '0, cmd_driven = '1;
  logic [PHASES-1:0] boot_lo = '0, top, bot;
  logic [2:0]        sys_lo = '0;
  logic              en;
  gate_out_type      gates;
  int seed = 11439, fails = 0, checks_done = 0, n, off_run, overlap;

  always #2.5 clk = ~clk;

  pwm_source_model src_u (.clk(clk), .rst(rst), .en_req(en_req),
    .top_req(top_req), .bot_req(bot_req), .en(en), .top(top), .bot(bot));
  gate_driver_control dut_u (.clk(clk), .rst(rst),
    .driver_enable_port_bit(en), .pwm_top_phase(top),
    .pwm_bottom_phase(bot), .enable_driven(enable_driven),
    .cmd_driven(cmd_driven), .supply_lockout(sys_lo[0]),
    .regulator_lockout(sys_lo[1]), .thermal_lockout(sys_lo[2]),
    .bootstrap_lockout(boot_lo), .gates(gates));

  // Steady-state gates; undriven lines read as their pulls
  function automatic gate_out_type expect_gates();
    logic              e;
    logic [PHASES-1:0] t, b;
    e = en_req & enable_driven & ~|sys_lo;
    t = top_req & cmd_driven;
    b = bot_req | ~cmd_driven;
    expect_gates.high_gate_out = {PHASES{e}} & t & b & ~boot_lo;
    expect_gates.low_gate_out  = {PHASES{e}} & ~t & ~b;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h want %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // Phase 0 low to high through a command gap of g cycles
  task automatic dead_run(input int g);
    top_req[0] <= 1'b0;
    bot_req[0] <= 1'b0;
    cyc(HOLD);
    bot_req[0] <= 1'b1;
    off_run = 0;
    overlap = 0;
    for (n = 1; n < 400 && gates.high_gate_out[0] !== 1'b1; n++) begin
      @(posedge clk);
      if (n == g) top_req[0] <= 1'b1;
      off_run += (gates.high_gate_out[0] | gates.low_gate_out[0]) === 0;
      overlap += (gates.high_gate_out[0] & gates.low_gate_out[0]) !== 1'b0;
    end
    if (n >= 400) begin
      fails++;
      stop_test();
    end
    check(32'(off_run >= ((g > DEAD_CYCLES) ? g : DEAD_CYCLES)), 1);
    check(overlap, 0);
  endtask

  initial begin
    cyc(16);
    rst <= 1'b0;
    en_req <= 1'b1;
    cyc(HOLD);
    // Compare mid-cycle, away from the edge that moves the gates
    @(negedge clk);
    check(gates, expect_gates());
    @(posedge clk);
    // Random commands, pulls and bootstrap lock-outs
    for (int i = 0; i < 16; i++) begin
      en_req <= ($random(seed) % 5) != 0;
      enable_driven <= ($random(seed) % 4) != 0;
      top_req <= PHASES'($random(seed));
      bot_req <= PHASES'($random(seed));
      cmd_driven <= PHASES'($random(seed) | $random(seed));
      boot_lo <= PHASES'($random(seed) & $random(seed));
      cyc(HOLD);
      @(negedge clk);
      check(gates, expect_gates());
      @(posedge clk);
    end
    {en_req, enable_driven, cmd_driven, boot_lo} <= {2'b11, 3'h7, 3'h0};
    top_req <= 3'h1;
    bot_req <= 3'h1;
    cyc(HOLD);
    // Each whole-device lock-out, then release
    for (int i = 0; i < 3; i++) begin
      sys_lo <= 3'h1 << i;
      cyc(6);
      @(negedge clk);
      check(gates, expect_gates());
      @(posedge clk);
      sys_lo <= 3'h0;
      cyc(HOLD);
      @(negedge clk);
      check(gates, expect_gates());
      @(posedge clk);
    end
    dead_run(1);
    dead_run(60);
    // Too-short pulses on each side out of the mixed state
    for (int k = 0; k < 2; k++) begin
      {top_req[0], bot_req[0]} <= 2'b01;
      cyc(HOLD);
      {top_req[0], bot_req[0]} <= {2{k[0]}};
      cyc(MINON_CYCLES - 2);
      {top_req[0], bot_req[0]} <= 2'b01;
      n = 0;
      repeat (100) begin
        @(posedge clk);
        n += (gates.high_gate_out[0] | gates.low_gate_out[0]) !== 0;
      end
      check(n, 0);
    end
    stop_test();
  end
endmodule // gate_driver_control_test
